/* clock_switch_pkg.sv */
// Constants and types for the system clock source switch
`default_nettype none
package clock_switch_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_STATUS = 6'h00;
  localparam logic [5:0] OFS_RUN_CFG = 6'h04;
  localparam logic [5:0] OFS_VERY_LOWPOWER_RUN_MODE_CFG = 6'h08;
  localparam logic [5:0] OFS_HIGHSPEED_RUN_MODE_CFG = 6'h0C;
  localparam logic [5:0] OFS_SLOW_CSR = 6'h10;
  localparam logic [5:0] OFS_SLOW_CFG = 6'h14;
  localparam logic [5:0] OFS_FAST_CSR = 6'h18;
  localparam logic [5:0] OFS_FAST_CFG = 6'h1C;
  localparam logic [5:0] OFS_OSC_CSR = 6'h20;
  localparam logic [5:0] OFS_PLL_CSR = 6'h24;
  localparam logic [5:0] OFS_PLL_CFG = 6'h28;
  localparam logic [5:0] OFS_PLL_FREQ = 6'h2C;

  // Field positions in the clock config registers
  localparam int SEL_LSB = 0;
  localparam int CORE_DIV_LSB = 16;
  localparam int SLOW_DIV_LSB = 4;
  // Field positions in the source control/status registers
  localparam int EN_BIT = 0;
  localparam int STEN_BIT = 1;
  localparam int LPEN_BIT = 2;
  localparam int VLD_BIT = 24;
  // Field positions in the PLL config register
  localparam int PLL_SRC_BIT = 0;
  localparam int PLL_PREDIV_LSB = 8;
  localparam int PLL_MULT_LSB = 16;

  // Source select codes
  localparam logic [3:0] CODE_OSC = 4'h1;
  localparam logic [3:0] CODE_SLOW = 4'h2;
  localparam logic [3:0] CODE_FAST = 4'h3;
  localparam logic [3:0] CODE_PLL = 4'h6;

  // PLL arithmetic: multiplier field offset and fixed output divide
  localparam logic [5:0] PLL_MULT_BASE = 6'h10;
  localparam logic [1:0] PLL_POST_DIV = 2'h2;
  // Reference frequencies in kHz feeding the PLL
  localparam logic [31:0] OSC_REF_KHZ = 32'h00001F40;
  localparam logic [31:0] FAST_REF_KHZ = 32'h0000BB80;

  // Reset values and the full-word byte enable
  localparam logic [3:0] RST_SELECT = CODE_SLOW;
  localparam logic [3:0] RST_DIV = 4'h0;
  localparam logic RST_SLOW_EN = 1'b1;
  localparam logic [31:0] FULL_WORD_BE = 32'h0000000F;

  // Power modes reported by the power mode controller
  typedef enum logic [2:0] {
    PM_RUN,
    PM_HIGHSPEED_RUN_MODE,
    PM_VERY_LOWPOWER_RUN_MODE,
    PM_STOP,
    PM_VERY_LOWPOWER_STOP_MODE,
    PM_LLS,
    PM_VERY_LOW_LEAKAGE_STOP_MODE
  } power_mode_type;

  typedef struct packed {
    logic [3:0] select;
    logic [3:0] core_div;
    logic [3:0] slow_div;
  } clk_cfg_type;

  typedef struct packed {
    logic enable;
    logic stop_enable;
    logic lowpower_enable;
    logic valid;
  } src_ctrl_type;

  typedef struct packed {
    logic source;
    logic [2:0] prediv;
    logic [4:0] mult;
  } pll_cfg_type;

  typedef struct packed {
    logic slow_rc;
    logic fast_rc;
    logic osc;
    logic pll;
  } src_run_type;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    clk_cfg_type run_cfg;
    clk_cfg_type very_lowpower_run_mode_cfg;
    clk_cfg_type highspeed_run_mode_cfg;
    src_ctrl_type slow;
    src_ctrl_type fast;
    src_ctrl_type osc;
    src_ctrl_type pll;
    logic slow_range;
    logic [1:0] fast_range;
    pll_cfg_type pll_cfg;
    logic [3:0] current;
    logic [3:0] core_div;
    logic [3:0] slow_div;
    src_run_type run;
    logic [23:0] pll_khz;
  } state_type;
endpackage : clock_switch_pkg
`default_nettype wire

/* system_clock_source_switch.sv */
// System clock source selection with Avalon-MM register access
`default_nettype none
module system_clock_source_switch (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire clock_switch_pkg::power_mode_type power_mode,
  input wire logic slow_rc_ready,
  input wire logic fast_rc_ready,
  input wire logic osc_ready,
  input wire logic pll_lock,
  output logic [3:0] source_select_code,
  output logic [3:0] core_clock_divided,
  output logic [3:0] slow_bus_clock_divided,
  output clock_switch_pkg::src_run_type source_run,
  output logic slow_rc_range,
  output logic [1:0] fast_rc_range,
  output clock_switch_pkg::pll_cfg_type pll_config
);

  clock_switch_pkg::state_type state_ff;
  clock_switch_pkg::state_type nxt_state;
  clock_switch_pkg::clk_cfg_type active_cfg;
  logic wr_take;
  logic full_word;
  logic in_run;
  logic accept;
  logic [31:0] pll_ref_khz;
  logic [31:0] pll_calc;

  // Register read multiplexer, unmapped addresses read zero
  function automatic logic [31:0] read_mux(input logic [5:0] addr, input clock_switch_pkg::state_type s);
    logic [31:0] d;
    d = 32'h00000000;
    case (addr)
      clock_switch_pkg::OFS_STATUS: d[3:0] = s.current;
      clock_switch_pkg::OFS_RUN_CFG: d = cfg_word(s.run_cfg);
      clock_switch_pkg::OFS_VERY_LOWPOWER_RUN_MODE_CFG: d = cfg_word(s.very_lowpower_run_mode_cfg);
      clock_switch_pkg::OFS_HIGHSPEED_RUN_MODE_CFG: d = cfg_word(s.highspeed_run_mode_cfg);
      clock_switch_pkg::OFS_SLOW_CSR: d = csr_word(s.slow);
      clock_switch_pkg::OFS_SLOW_CFG: d[0] = s.slow_range;
      clock_switch_pkg::OFS_FAST_CSR: d = csr_word(s.fast);
      clock_switch_pkg::OFS_FAST_CFG: d[1:0] = s.fast_range;
      clock_switch_pkg::OFS_OSC_CSR: d = csr_word(s.osc);
      clock_switch_pkg::OFS_PLL_CSR: d = csr_word(s.pll);
      clock_switch_pkg::OFS_PLL_CFG: begin
        d[clock_switch_pkg::PLL_SRC_BIT] = s.pll_cfg.source;
        d[clock_switch_pkg::PLL_PREDIV_LSB +: 3] = s.pll_cfg.prediv;
        d[clock_switch_pkg::PLL_MULT_LSB +: 5] = s.pll_cfg.mult;
      end
      clock_switch_pkg::OFS_PLL_FREQ: d[23:0] = s.pll_khz;
      default: d = 32'h00000000;
    endcase
    return d;
  endfunction : read_mux

  // Packs a clock config into its register word
  function automatic logic [31:0] cfg_word(input clock_switch_pkg::clk_cfg_type c);
    logic [31:0] d;
    d = 32'h00000000;
    d[clock_switch_pkg::SEL_LSB +: 4] = c.select;
    d[clock_switch_pkg::CORE_DIV_LSB +: 4] = c.core_div;
    d[clock_switch_pkg::SLOW_DIV_LSB +: 4] = c.slow_div;
    return d;
  endfunction : cfg_word

  // Unpacks a register word into a clock config
  function automatic clock_switch_pkg::clk_cfg_type cfg_from(input logic [31:0] w);
    clock_switch_pkg::clk_cfg_type c;
    c.select = w[clock_switch_pkg::SEL_LSB +: 4];
    c.core_div = w[clock_switch_pkg::CORE_DIV_LSB +: 4];
    c.slow_div = w[clock_switch_pkg::SLOW_DIV_LSB +: 4];
    return c;
  endfunction : cfg_from

  // Packs a source control/status into its register word
  function automatic logic [31:0] csr_word(input clock_switch_pkg::src_ctrl_type c);
    logic [31:0] d;
    d = 32'h00000000;
    d[clock_switch_pkg::EN_BIT] = c.enable;
    d[clock_switch_pkg::STEN_BIT] = c.stop_enable;
    d[clock_switch_pkg::LPEN_BIT] = c.lowpower_enable;
    d[clock_switch_pkg::VLD_BIT] = c.valid;
    return d;
  endfunction : csr_word

  // Next-state logic: bus slave, source control, switching and stop gating
  always_comb begin
    nxt_state = state_ff;
    full_word = avs_byteenable == clock_switch_pkg::FULL_WORD_BE[3:0];
    wr_take = avs_write && !state_ff.waitreq && full_word;
    in_run = 1'b1;
    accept = 1'b0;
    active_cfg = state_ff.run_cfg;

    // One wait cycle, then the access completes
    nxt_state.waitreq = 1'b1;
    if ((avs_read || avs_write) && state_ff.waitreq) begin
      nxt_state.waitreq = 1'b0;
      nxt_state.rdata = avs_read ? read_mux(avs_address, state_ff) : 32'h00000000;
    end

    // Register writes, narrower writes are dropped
    if (wr_take) begin
      case (avs_address)
        clock_switch_pkg::OFS_RUN_CFG: nxt_state.run_cfg = cfg_from(avs_writedata);
        clock_switch_pkg::OFS_VERY_LOWPOWER_RUN_MODE_CFG: nxt_state.very_lowpower_run_mode_cfg = cfg_from(avs_writedata);
        clock_switch_pkg::OFS_HIGHSPEED_RUN_MODE_CFG: nxt_state.highspeed_run_mode_cfg = cfg_from(avs_writedata);
        clock_switch_pkg::OFS_SLOW_CSR: begin
          nxt_state.slow.enable = avs_writedata[clock_switch_pkg::EN_BIT];
          nxt_state.slow.stop_enable = avs_writedata[clock_switch_pkg::STEN_BIT];
          nxt_state.slow.lowpower_enable = avs_writedata[clock_switch_pkg::LPEN_BIT];
        end
        clock_switch_pkg::OFS_SLOW_CFG: begin
          if (!state_ff.slow.enable) begin
            nxt_state.slow_range = avs_writedata[0];
          end
        end
        clock_switch_pkg::OFS_FAST_CSR: begin
          nxt_state.fast.enable = avs_writedata[clock_switch_pkg::EN_BIT];
          nxt_state.fast.stop_enable = avs_writedata[clock_switch_pkg::STEN_BIT];
        end
        clock_switch_pkg::OFS_FAST_CFG: begin
          if (!state_ff.fast.enable) begin
            nxt_state.fast_range = avs_writedata[1:0];
          end
        end
        clock_switch_pkg::OFS_OSC_CSR: begin
          nxt_state.osc.enable = avs_writedata[clock_switch_pkg::EN_BIT];
          nxt_state.osc.stop_enable = avs_writedata[clock_switch_pkg::STEN_BIT];
          nxt_state.osc.lowpower_enable = avs_writedata[clock_switch_pkg::LPEN_BIT];
        end
        clock_switch_pkg::OFS_PLL_CSR: begin
          nxt_state.pll.enable = avs_writedata[clock_switch_pkg::EN_BIT];
          nxt_state.pll.stop_enable = avs_writedata[clock_switch_pkg::STEN_BIT];
        end
        clock_switch_pkg::OFS_PLL_CFG: begin
          nxt_state.pll_cfg.source = avs_writedata[clock_switch_pkg::PLL_SRC_BIT];
          nxt_state.pll_cfg.prediv = avs_writedata[clock_switch_pkg::PLL_PREDIV_LSB +: 3];
          nxt_state.pll_cfg.mult = avs_writedata[clock_switch_pkg::PLL_MULT_LSB +: 5];
        end
        default: nxt_state.rdata = nxt_state.rdata;
      endcase
    end

    // Valid follows the analog ready only while the source is enabled, and for the PLL only while its reference is also valid
    nxt_state.slow.valid = state_ff.slow.enable && slow_rc_ready;
    nxt_state.fast.valid = state_ff.fast.enable && fast_rc_ready;
    nxt_state.osc.valid = state_ff.osc.enable && osc_ready;
    nxt_state.pll.valid = state_ff.pll.enable && pll_lock
      && (state_ff.pll_cfg.source ? state_ff.fast.valid : state_ff.osc.valid);

    // PLL output estimate: reference / prediv * multiplier / 2
    pll_ref_khz = state_ff.pll_cfg.source ? clock_switch_pkg::FAST_REF_KHZ
                                          : clock_switch_pkg::OSC_REF_KHZ;
    // Widen before adding one so a predivider field of 7 divides by 8, not by zero
    pll_calc = pll_ref_khz / {28'h0000000, {1'b0, state_ff.pll_cfg.prediv} + 4'h1}
      * {26'h0000000, clock_switch_pkg::PLL_MULT_BASE + {1'b0, state_ff.pll_cfg.mult}}
      / {30'h00000000, clock_switch_pkg::PLL_POST_DIV};
    nxt_state.pll_khz = pll_calc[23:0];

    // Pick the config of the active run mode
    case (power_mode)
      clock_switch_pkg::PM_RUN: active_cfg = state_ff.run_cfg;
      clock_switch_pkg::PM_HIGHSPEED_RUN_MODE: active_cfg = state_ff.highspeed_run_mode_cfg;
      clock_switch_pkg::PM_VERY_LOWPOWER_RUN_MODE: active_cfg = state_ff.very_lowpower_run_mode_cfg;
      default: in_run = 1'b0;
    endcase

    // Accept the request only if the source is usable in this mode
    case (active_cfg.select)
      clock_switch_pkg::CODE_SLOW: accept = state_ff.slow.enable && state_ff.slow.valid
        && (power_mode != clock_switch_pkg::PM_VERY_LOWPOWER_RUN_MODE || state_ff.slow.lowpower_enable);
      clock_switch_pkg::CODE_FAST: accept = state_ff.fast.enable && state_ff.fast.valid
        && power_mode != clock_switch_pkg::PM_VERY_LOWPOWER_RUN_MODE;
      clock_switch_pkg::CODE_OSC: accept = state_ff.osc.enable && state_ff.osc.valid;
      clock_switch_pkg::CODE_PLL: accept = state_ff.pll.enable && state_ff.pll.valid
        && power_mode != clock_switch_pkg::PM_VERY_LOWPOWER_RUN_MODE;
      default: accept = 1'b0;
    endcase

    // Switch source and dividers together; otherwise hold them
    if (in_run && accept) begin
      nxt_state.current = active_cfg.select;
      nxt_state.core_div = active_cfg.core_div;
      nxt_state.slow_div = active_cfg.slow_div;
    end

    // Per-source run gating in run and stop modes
    nxt_state.run.slow_rc = state_ff.slow.enable && (in_run
      || (power_mode == clock_switch_pkg::PM_STOP && state_ff.slow.stop_enable)
      || (power_mode == clock_switch_pkg::PM_VERY_LOWPOWER_STOP_MODE && state_ff.slow.stop_enable
          && state_ff.slow.lowpower_enable));
    nxt_state.run.fast_rc = state_ff.fast.enable && ((in_run && power_mode != clock_switch_pkg::PM_VERY_LOWPOWER_RUN_MODE)
      || (power_mode == clock_switch_pkg::PM_STOP && state_ff.fast.stop_enable));
    nxt_state.run.osc = state_ff.osc.enable && (in_run
      || (power_mode == clock_switch_pkg::PM_STOP && state_ff.osc.stop_enable)
      || ((power_mode == clock_switch_pkg::PM_VERY_LOWPOWER_STOP_MODE || power_mode == clock_switch_pkg::PM_LLS)
          && state_ff.osc.stop_enable && state_ff.osc.lowpower_enable));
    nxt_state.run.pll = state_ff.pll.enable && ((in_run && power_mode != clock_switch_pkg::PM_VERY_LOWPOWER_RUN_MODE)
      || (power_mode == clock_switch_pkg::PM_STOP && state_ff.pll.stop_enable));
  end

  // State register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= '0;
      state_ff.waitreq <= 1'b1;
      state_ff.run_cfg.select <= clock_switch_pkg::RST_SELECT;
      state_ff.very_lowpower_run_mode_cfg.select <= clock_switch_pkg::RST_SELECT;
      state_ff.highspeed_run_mode_cfg.select <= clock_switch_pkg::RST_SELECT;
      state_ff.current <= clock_switch_pkg::RST_SELECT;
      state_ff.core_div <= clock_switch_pkg::RST_DIV;
      state_ff.slow_div <= clock_switch_pkg::RST_DIV;
      state_ff.slow.enable <= clock_switch_pkg::RST_SLOW_EN;
      state_ff.run.slow_rc <= clock_switch_pkg::RST_SLOW_EN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = state_ff.rdata;
  assign avs_waitrequest = state_ff.waitreq;
  assign source_select_code = state_ff.current;
  assign core_clock_divided = state_ff.core_div;
  assign slow_bus_clock_divided = state_ff.slow_div;
  assign source_run = state_ff.run;
  assign slow_rc_range = state_ff.slow_range;
  assign fast_rc_range = state_ff.fast_range;
  assign pll_config = state_ff.pll_cfg;

endmodule : system_clock_source_switch
`default_nettype wire

/* placeholder_never.sv */
// Empty compilation unit kept for file ordering
`default_nettype none
`default_nettype wire

/* clock_switch_asserts.sv */
// Assertion checker for the system clock source switch ports
`default_nettype none
module clock_switch_asserts (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire clock_switch_pkg::power_mode_type power_mode,
  input wire logic [3:0] source_select_code,
  input wire clock_switch_pkg::src_run_type source_run
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // Source code, bus answer and per-mode source permissions
  property p_code_legal;
    source_select_code inside {4'h1, 4'h2, 4'h3, 4'h6};
  endproperty
  a_code_legal: assert property (p_code_legal) else $error("active code outside the source set");
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer not a single cycle");
  property p_no_fast_very_lowpower_run_mode;
    $changed(source_select_code) && $past(power_mode) == clock_switch_pkg::PM_VERY_LOWPOWER_RUN_MODE |-> source_select_code != 4'h3;
  endproperty
  a_no_fast_very_lowpower_run_mode: assert property (p_no_fast_very_lowpower_run_mode) else $error("fast RC picked in low power run");
  property p_no_pll_very_lowpower_run_mode;
    $changed(source_select_code) && $past(power_mode) == clock_switch_pkg::PM_VERY_LOWPOWER_RUN_MODE |-> source_select_code != 4'h6;
  endproperty
  a_no_pll_very_lowpower_run_mode: assert property (p_no_pll_very_lowpower_run_mode) else $error("PLL picked in low power run");
  property p_fast_deep_off;
    $past(power_mode) inside {clock_switch_pkg::PM_VERY_LOWPOWER_STOP_MODE, clock_switch_pkg::PM_LLS, clock_switch_pkg::PM_VERY_LOW_LEAKAGE_STOP_MODE} |-> !source_run.fast_rc;
  endproperty
  a_fast_deep_off: assert property (p_fast_deep_off) else $error("fast RC runs in deep stop");
  property p_pll_deep_off;
    $past(power_mode) inside {clock_switch_pkg::PM_VERY_LOWPOWER_STOP_MODE, clock_switch_pkg::PM_LLS, clock_switch_pkg::PM_VERY_LOW_LEAKAGE_STOP_MODE} |-> !source_run.pll;
  endproperty
  a_pll_deep_off: assert property (p_pll_deep_off) else $error("PLL runs in deep stop");
  property p_osc_very_low_leakage_stop_mode_off;
    $past(power_mode) == clock_switch_pkg::PM_VERY_LOW_LEAKAGE_STOP_MODE |-> !source_run.osc;
  endproperty
  a_osc_very_low_leakage_stop_mode_off: assert property (p_osc_very_low_leakage_stop_mode_off) else $error("oscillator runs in deepest stop");
  property p_slow_leak_off;
    $past(power_mode) inside {clock_switch_pkg::PM_LLS, clock_switch_pkg::PM_VERY_LOW_LEAKAGE_STOP_MODE} |-> !source_run.slow_rc;
  endproperty
  a_slow_leak_off: assert property (p_slow_leak_off) else $error("slow RC runs in leakage stop");
endmodule : clock_switch_asserts
`default_nettype wire

/* tb_system_clock_source_switch.sv */
// Self-checking testbench for the system clock source switch
`default_nettype none
module tb_system_clock_source_switch;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, avs_read, avs_write, avs_waitrequest, slow_rc_ready, fast_rc_ready, osc_ready, pll_lock;
  logic slow_rc_range;
  logic [1:0] fast_rc_range;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rv, lfsr;
  logic [3:0] avs_byteenable, source_select_code, core_clock_divided, slow_bus_clock_divided;
  clock_switch_pkg::power_mode_type power_mode;
  clock_switch_pkg::src_run_type source_run;
  clock_switch_pkg::pll_cfg_type pll_config;
  int error_cnt, n_compared, m_code, m_cd, m_sd, m_lp;
  int m_cfg[3][3];
  bit m_en[4];
  int pt[2][4] = '{'{1, 5, 2, 72000}, '{0, 0, 8, 96000}};
  int codes[5] = '{1, 2, 3, 6, 5};

  system_clock_source_switch u_system_clock_source_switch (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .power_mode(power_mode),
    .slow_rc_ready(slow_rc_ready), .fast_rc_ready(fast_rc_ready), .osc_ready(osc_ready), .pll_lock(pll_lock),
    .source_select_code(source_select_code), .core_clock_divided(core_clock_divided),
    .slow_bus_clock_divided(slow_bus_clock_divided), .source_run(source_run), .slow_rc_range(slow_rc_range),
    .fast_rc_range(fast_rc_range), .pll_config(pll_config));

  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // Model: may a code be taken in a given run mode
  function automatic bit legal(input int c, input int md);
    case (c)
      1: return m_en[2];
      2: return m_en[0] && (md != 2 || m_lp != 0);
      3: return m_en[1] && md != 2;
      6: return m_en[3] && md != 2;
      default: return 1'b0;
    endcase
  endfunction : legal

  task automatic end_sim();
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
    int i;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
      if (i > 40) begin
        error_cnt++;
        end_sim();
      end
    end while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // One more edge so a committed write is visible to the caller
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [5:0] a);
    bus(a, 1'b0, 32'h0, 4'hF);
  endtask : rd

  // Write a mode config with random dividers and update the model
  task automatic cfg(input int md, input int code, input logic [3:0] be);
    logic [31:0] d;
    logic [5:0] a;
    d = (rnd() & 32'h000F00F0) | code;
    a = md == 0 ? clock_switch_pkg::OFS_RUN_CFG : md == 1 ? clock_switch_pkg::OFS_HIGHSPEED_RUN_MODE_CFG : clock_switch_pkg::OFS_VERY_LOWPOWER_RUN_MODE_CFG;
    bus(a, 1'b1, d, be);
    if (be == 4'hF) m_cfg[md] = '{code, d[19:16], d[7:4]};
  endtask : cfg

  // Let the switch settle, then compare status and outputs with the model
  task automatic settle();
    int md;
    repeat (6) @(posedge mclk);
    md = int'(power_mode);
    if (md < 3 && legal(m_cfg[md][0], md)) begin
      m_code = m_cfg[md][0];
      m_cd = m_cfg[md][1];
      m_sd = m_cfg[md][2];
    end
    rd(clock_switch_pkg::OFS_STATUS);
    chk("status", m_code, {28'h0, rv[3:0]});
    chk("code", m_code, {28'h0, source_select_code});
    chk("core_div", m_cd, {28'h0, core_clock_divided});
    chk("slow_div", m_sd, {28'h0, slow_bus_clock_divided});
  endtask : settle

  task automatic wait_valid(input logic [5:0] a);
    int i;
    i = 0;
    rd(a);
    while (rv[24] !== 1'b1 && i < 20) begin
      rd(a);
      i++;
    end
    chk("valid", 1, {31'h0, rv[24]});
    if (rv[24] !== 1'b1) end_sim();
  endtask : wait_valid

  task automatic go(input int md);
    @(posedge mclk);
    power_mode <= clock_switch_pkg::power_mode_type'(md);
  endtask : go

  // Main sequence
  initial begin
    {rstn, avs_read, avs_write, fast_rc_ready, osc_ready, pll_lock} = 6'h0;
    {avs_address, avs_writedata, avs_byteenable} = '0;
    slow_rc_ready = 1'b1;
    power_mode = clock_switch_pkg::PM_RUN;
    lfsr = 32'h72CB100A;
    m_cfg = '{'{2, 0, 0}, '{2, 0, 0}, '{2, 0, 0}};
    m_en = '{1, 0, 0, 0};
    {error_cnt, n_compared, m_cd, m_sd, m_lp} = '0;
    m_code = 2;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    settle();
    rd(6'h30);
    chk("unmapped", 0, rv);
    wr(clock_switch_pkg::OFS_STATUS, 32'h6);
    cfg(0, 1, 4'hF);
    settle();
    osc_ready <= 1'b1;
    wr(clock_switch_pkg::OFS_OSC_CSR, 32'h3);
    wait_valid(clock_switch_pkg::OFS_OSC_CSR);
    m_en[2] = 1;
    settle();
    fast_rc_ready <= 1'b1;
    wr(clock_switch_pkg::OFS_FAST_CSR, 32'h3);
    wait_valid(clock_switch_pkg::OFS_FAST_CSR);
    m_en[1] = 1;
    cfg(0, 3, 4'hF);
    settle();
    wr(clock_switch_pkg::OFS_FAST_CFG, 32'h3);
    chk("fast_range", 0, {30'h0, fast_rc_range});
    wr(clock_switch_pkg::OFS_SLOW_CFG, 32'h1);
    chk("slow_range", 0, {31'h0, slow_rc_range});
    wr(clock_switch_pkg::OFS_SLOW_CSR, 32'h0);
    m_en[0] = 0;
    wr(clock_switch_pkg::OFS_SLOW_CFG, 32'h1);
    chk("slow_range", 1, {31'h0, slow_rc_range});
    wr(clock_switch_pkg::OFS_SLOW_CSR, 32'h3);
    wait_valid(clock_switch_pkg::OFS_SLOW_CSR);
    m_en[0] = 1;
    for (int k = 0; k < 2; k++) begin
      wr(clock_switch_pkg::OFS_PLL_CFG, pt[k][0] | pt[k][1] << 8 | pt[k][2] << 16);
      rd(clock_switch_pkg::OFS_PLL_FREQ);
      chk("pll_freq", pt[k][3], rv);
      chk("pll_config", pt[k][0] * 256 + pt[k][1] * 32 + pt[k][2], {23'h0, pll_config});
    end
    wr(clock_switch_pkg::OFS_PLL_CSR, 32'h3);
    cfg(0, 6, 4'hF);
    settle();
    pll_lock <= 1'b1;
    wait_valid(clock_switch_pkg::OFS_PLL_CSR);
    m_en[3] = 1;
    settle();
    cfg(0, 2, 4'h3);
    settle();
    foreach (codes[i]) begin
      cfg(0, codes[i], 4'hF);
      settle();
    end
    cfg(1, 1, 4'hF);
    cfg(2, 3, 4'hF);
    go(1);
    settle();
    go(2);
    settle();
    cfg(2, 6, 4'hF);
    settle();
    cfg(2, 2, 4'hF);
    settle();
    wr(clock_switch_pkg::OFS_SLOW_CSR, 32'h7);
    m_lp = 1;
    settle();
    cfg(2, 1, 4'hF);
    settle();
    cfg(0, 6, 4'hF);
    go(0);
    settle();
    for (int lp = 0; lp < 2; lp++) begin
      wr(clock_switch_pkg::OFS_SLOW_CSR, 3 | lp << 2);
      wr(clock_switch_pkg::OFS_OSC_CSR, 3 | lp << 2);
      m_lp = lp;
      for (int md = 3; md < 7; md++) begin
        go(md);
        repeat (6) @(posedge mclk);
        chk("run", {md == 3 || (md == 4 && lp == 1), md == 3, md == 3 || (md < 6 && lp == 1), md == 3},
            {28'h0, source_run});
        chk("stop_code", m_code, {28'h0, source_select_code});
      end
      go(0);
      settle();
    end
    end_sim();
  end
endmodule : tb_system_clock_source_switch

bind system_clock_source_switch clock_switch_asserts u_clock_switch_asserts (.mclk(mclk), .rstn(rstn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .power_mode(power_mode),
  .source_select_code(source_select_code), .source_run(source_run));
`default_nettype wire
